// *** bbc_pkg.sv ***
/*
 bbc_pkg: state codes and field constants shared by the buffer-control
 block. Assumes a single bus-clock sampled domain.
*/
package bbc_pkg;
    timeunit 1ns;
    timeprecision 1ps;
    // master side states, one-hot
    typedef enum logic [4:0] {
        M_IDLE = 5'h01,
        M_ADDR = 5'h02,
        M_DATA = 5'h04,
        M_DONE = 5'h08,
        M_HOLD = 5'h10
    } bbc_mst_e;
    // slave side states, one-hot
    typedef enum logic [4:0] {
        S_IDLE = 5'h01,
        S_DEC  = 5'h02,
        S_ACT  = 5'h04,
        S_ACK  = 5'h08,
        S_END  = 5'h10
    } bbc_slv_e;
    // data load clock high time, in bus clock cycles
    localparam logic [1:0] LOAD_HI_FIRST = 2'h2;
    localparam logic [1:0] LOAD_HI_ONE   = 2'h1;
    localparam logic [1:0] LOAD_HI_NONE  = 2'h0;
endpackage : bbc_pkg

// *** bbc_buffer_ctrl.sv ***
/*
 bbc_buffer_ctrl: enables and load clocks that steer multiplexed
 address/data between the backplane and the local board, plus the
 slot-match sample after a start cycle.
 Assumes BUS_CLK and all inputs are synchronous to REF_CLK, which runs
 at least four times faster than BUS_CLK; the master/slave sequencers,
 arbitration and byte decode live outside and drive the cycle inputs.
*/
// Contract
// - master write: drive enable until acknowledge
// - master read: drive enable one cycle
// - slave read: drive enable in ack cycle
// - address enable low after slave grant
// - address enable high after grant released
// - early grant: address enable after start
// - master read: load clock on ack/interim
// - slave write: load clock on grant
// - block write: first load clock two cycles
// - block write early grant: clock after start
// - interim ack gives one-cycle load clock
// - last block load clock from local ack
// - master read: data enable until hold released
// - slave write: data enable follows grant
// - sample slot match cycle after start
// - address load clock on start sample edge
// - address select low one start cycle
// - backplane ack after local ack sampled
module bbc_buffer_ctrl (
    // clock and reset
    input  wire logic REF_CLK,
    input  wire logic NRST,
    // backplane side
    input  wire logic BUS_CLK,
    input  wire logic BUS_START_N,
    input  wire logic BUS_ACK_N,
    input  wire logic BUS_TM0_N,
    output logic      BUS_ACK_OUT_N,
    // cycle description from byte decode / sequencer
    input  wire logic MST_START,
    input  wire logic WRITE,
    input  wire logic BLOCK_XFER,
    // local board handshakes
    input  wire logic SLOT_MATCH_N,
    input  wire logic SLAVE_GRANT_N,
    input  wire logic SLAVE_INTERIM_ACK_N,
    input  wire logic LOCAL_ACK_N,
    input  wire logic MASTER_HOLD_N,
    // buffer controls
    output logic      BUS_DRIVE_ENABLE_N,
    output logic      ADDR_SELECT_N,
    output logic      LOCAL_ADDR_LOAD_CLK,
    output logic      LOCAL_ADDR_ENABLE_N,
    output logic      LOCAL_DATA_LOAD_CLK,
    output logic      LOCAL_DATA_ENABLE_N
);
    timeunit 1ns;
    timeprecision 1ps;
    logic               bclk_q;   // previous bus clock level
    logic               rise;     // driving edge strobe
    logic               fall;     // sample edge strobe
    bbc_pkg::bbc_mst_e  m_st;     // master cycle state
    bbc_pkg::bbc_slv_e  s_st;     // slave cycle state
    logic               m_wr;     // master cycle is a write
    logic               m_blk;    // master cycle is a block
    logic               s_wr;     // slave cycle is a write
    logic               s_blk;    // slave cycle is a block
    logic               gnt_seen; // grant already given this cycle
    logic [1:0]         dcnt;     // remaining load clock high cycles
    logic               m_rd_evt; // master read data arrives
    logic               s_busy;   // slave past the start cycle

    // edge strobes from the sampled bus clock
    always_ff @(posedge REF_CLK) begin
        if (!NRST) begin
            bclk_q <= 1'b0;
        end else begin
            bclk_q <= BUS_CLK;
        end
    end
    assign rise = BUS_CLK & ~bclk_q;
    assign fall = ~BUS_CLK & bclk_q;

    // ack, or interim ack in a block read, seen by a reading master
    assign m_rd_evt = (m_st == bbc_pkg::M_DATA) && !m_wr &&
                      (!BUS_ACK_N || (m_blk && !BUS_TM0_N));
    assign s_busy   = (s_st != bbc_pkg::S_IDLE);

    // master sequencing: start on a driving edge, ack on a sample edge
    always_ff @(posedge REF_CLK) begin
        if (!NRST) begin
            m_st  <= bbc_pkg::M_IDLE;
            m_wr  <= 1'b0;
            m_blk <= 1'b0;
        end else begin
            unique case (m_st)
                bbc_pkg::M_IDLE: begin
                    if (rise && MST_START) begin
                        m_st  <= bbc_pkg::M_ADDR;
                        m_wr  <= WRITE;
                        m_blk <= BLOCK_XFER;
                    end
                end
                bbc_pkg::M_ADDR: begin
                    // start lasts one bus clock
                    if (rise) begin
                        m_st <= bbc_pkg::M_DATA;
                    end
                end
                bbc_pkg::M_DATA: begin
                    // hold keeps read data on the board past the cycle
                    if (fall && !BUS_ACK_N) begin
                        if (!m_wr && !MASTER_HOLD_N) begin
                            m_st <= bbc_pkg::M_HOLD;
                        end else begin
                            m_st <= bbc_pkg::M_DONE;
                        end
                    end
                end
                bbc_pkg::M_DONE: begin
                    if (rise) begin
                        m_st <= bbc_pkg::M_IDLE;
                    end
                end
                bbc_pkg::M_HOLD: begin
                    if (fall && MASTER_HOLD_N) begin
                        m_st <= bbc_pkg::M_IDLE;
                    end
                end
                default: begin
                    m_st <= bbc_pkg::M_IDLE;
                end
            endcase
        end
    end

    // slave sequencing, all decisions on sample edges
    always_ff @(posedge REF_CLK) begin
        if (!NRST) begin
            s_st     <= bbc_pkg::S_IDLE;
            s_wr     <= 1'b0;
            s_blk    <= 1'b0;
            gnt_seen <= 1'b0;
        end else if (fall) begin
            unique case (s_st)
                bbc_pkg::S_IDLE: begin
                    if (!BUS_START_N) begin
                        s_st     <= bbc_pkg::S_DEC;
                        s_wr     <= WRITE;
                        s_blk    <= BLOCK_XFER;
                        gnt_seen <= !SLAVE_GRANT_N;
                    end
                end
                bbc_pkg::S_DEC: begin
                    // board not addressed: drop the cycle
                    if (SLOT_MATCH_N) begin
                        s_st <= bbc_pkg::S_IDLE;
                    end else begin
                        s_st <= bbc_pkg::S_ACT;
                    end
                    gnt_seen <= gnt_seen | !SLAVE_GRANT_N;
                end
                bbc_pkg::S_ACT: begin
                    gnt_seen <= gnt_seen | !SLAVE_GRANT_N;
                    if (!LOCAL_ACK_N) begin
                        s_st <= bbc_pkg::S_ACK;
                    end
                end
                bbc_pkg::S_ACK: begin
                    s_st <= bbc_pkg::S_END;
                end
                bbc_pkg::S_END: begin
                    // wait for the board to drop its grant
                    if (SLAVE_GRANT_N) begin
                        s_st <= bbc_pkg::S_IDLE;
                    end
                end
                default: begin
                    s_st <= bbc_pkg::S_IDLE;
                end
            endcase
        end
    end

    // backplane drive enable, changes on driving edges only
    always_ff @(posedge REF_CLK) begin
        if (!NRST) begin
            BUS_DRIVE_ENABLE_N <= 1'b1;
        end else if (rise) begin
            BUS_DRIVE_ENABLE_N <= !(
                (m_st == bbc_pkg::M_IDLE && MST_START) ||
                (m_st == bbc_pkg::M_ADDR && m_wr) ||
                (m_st == bbc_pkg::M_DATA && m_wr) ||
                (s_st == bbc_pkg::S_ACK && !s_wr));
        end
    end

    // backplane ack, on the driving edge after local ack sampled
    always_ff @(posedge REF_CLK) begin
        if (!NRST) begin
            BUS_ACK_OUT_N <= 1'b1;
        end else if (rise) begin
            BUS_ACK_OUT_N <= (s_st != bbc_pkg::S_ACK);
        end
    end

    // address/data select, low for the start cycle only
    always_ff @(posedge REF_CLK) begin
        if (!NRST) begin
            ADDR_SELECT_N <= 1'b1;
        end else if (rise) begin
            ADDR_SELECT_N <= !(m_st == bbc_pkg::M_IDLE && MST_START);
        end
    end

    // address load clock, high from the start sample edge
    always_ff @(posedge REF_CLK) begin
        if (!NRST) begin
            LOCAL_ADDR_LOAD_CLK <= 1'b0;
        end else if (fall) begin
            LOCAL_ADDR_LOAD_CLK <= (m_st == bbc_pkg::M_ADDR) ||
                (s_st == bbc_pkg::S_IDLE && !BUS_START_N);
        end
    end

    // local address enable follows the sampled slave grant
    always_ff @(posedge REF_CLK) begin
        if (!NRST) begin
            LOCAL_ADDR_ENABLE_N <= 1'b1;
        end else if (fall) begin
            if (s_st == bbc_pkg::S_IDLE) begin
                // grant already low during start
                LOCAL_ADDR_ENABLE_N <= BUS_START_N || SLAVE_GRANT_N;
            end else begin
                LOCAL_ADDR_ENABLE_N <= SLAVE_GRANT_N;
            end
        end
    end

    // local data enable: master read ack and hold, or slave write grant
    always_ff @(posedge REF_CLK) begin
        if (!NRST) begin
            LOCAL_DATA_ENABLE_N <= 1'b1;
        end else if (fall) begin
            LOCAL_DATA_ENABLE_N <= !(
                (m_st == bbc_pkg::M_DATA && !m_wr && !BUS_ACK_N) ||
                (m_st == bbc_pkg::M_HOLD && !MASTER_HOLD_N) ||
                (s_busy && s_wr && !SLAVE_GRANT_N));
        end
    end

    // data load clock: pulse stretched by a small down counter;
    // slave interim acks during a pulse are ignored on purpose
    always_ff @(posedge REF_CLK) begin
        if (!NRST) begin
            LOCAL_DATA_LOAD_CLK <= 1'b0;
            dcnt                <= bbc_pkg::LOAD_HI_NONE;
        end else if (fall) begin
            if (m_rd_evt) begin
                LOCAL_DATA_LOAD_CLK <= 1'b1;
                dcnt                <= bbc_pkg::LOAD_HI_ONE;
            end else if (s_st == bbc_pkg::S_IDLE && !BUS_START_N &&
                         WRITE && !SLAVE_GRANT_N) begin
                LOCAL_DATA_LOAD_CLK <= 1'b1;
                dcnt <= BLOCK_XFER ? bbc_pkg::LOAD_HI_FIRST : bbc_pkg::LOAD_HI_ONE;
            end else if (s_busy && s_wr && !gnt_seen && !SLAVE_GRANT_N) begin
                LOCAL_DATA_LOAD_CLK <= 1'b1;
                dcnt <= s_blk ? bbc_pkg::LOAD_HI_FIRST : bbc_pkg::LOAD_HI_ONE;
            end else if (dcnt > bbc_pkg::LOAD_HI_ONE) begin
                dcnt <= dcnt - bbc_pkg::LOAD_HI_ONE;
            end else if (dcnt == bbc_pkg::LOAD_HI_ONE) begin
                LOCAL_DATA_LOAD_CLK <= 1'b0;
                dcnt                <= bbc_pkg::LOAD_HI_NONE;
            end else if (s_st == bbc_pkg::S_ACT && s_wr && s_blk &&
                         gnt_seen && !LOCAL_ACK_N) begin
                LOCAL_DATA_LOAD_CLK <= 1'b1;
                dcnt                <= bbc_pkg::LOAD_HI_ONE;
            end else if (s_st == bbc_pkg::S_ACT && s_wr && s_blk &&
                         gnt_seen && !SLAVE_INTERIM_ACK_N) begin
                LOCAL_DATA_LOAD_CLK <= 1'b1;
                dcnt                <= bbc_pkg::LOAD_HI_ONE;
            end
        end
    end

    // master read releases the drive enable after one cycle
    rd_drive_a: assert property (@(posedge REF_CLK) disable iff (!NRST)
        (rise && m_st == bbc_pkg::M_ADDR && !m_wr) |=> BUS_DRIVE_ENABLE_N)
        else $error("read drive enable held past start");
    // master write keeps driving until ack
    wr_drive_a: assert property (@(posedge REF_CLK) disable iff (!NRST)
        (m_st == bbc_pkg::M_DATA && m_wr && $past(m_st) == bbc_pkg::M_DATA)
        |-> !BUS_DRIVE_ENABLE_N)
        else $error("write drive enable dropped before ack");
    // address enable tracks grant once busy
    addr_en_follow_a: assert property (@(posedge REF_CLK) disable iff (!NRST)
        (fall && s_busy) |=> (LOCAL_ADDR_ENABLE_N == $past(SLAVE_GRANT_N)))
        else $error("address enable not following grant");
    // data enable held while hold is asserted
    data_en_hold_a: assert property (@(posedge REF_CLK) disable iff (!NRST)
        (m_st == bbc_pkg::M_HOLD && $past(m_st) == bbc_pkg::M_HOLD)
        |-> !LOCAL_DATA_ENABLE_N)
        else $error("data enable released during hold");
    // select low right after a master start
    sel_start_a: assert property (@(posedge REF_CLK) disable iff (!NRST)
        (rise && m_st == bbc_pkg::M_IDLE && MST_START)
        |=> !ADDR_SELECT_N ##1 (m_st == bbc_pkg::M_ADDR))
        else $error("address select not low at start");
    // local ack becomes backplane ack on the next driving edge
    ack_out_a: assert property (@(posedge REF_CLK) disable iff (!NRST)
        (rise && s_st == bbc_pkg::S_ACK) |=> !BUS_ACK_OUT_N)
        else $error("backplane ack missing");
    // mismatch in decode cycle drops the slave cycle
    match_a: assert property (@(posedge REF_CLK) disable iff (!NRST)
        (fall && s_st == bbc_pkg::S_DEC && SLOT_MATCH_N)
        |=> (s_st == bbc_pkg::S_IDLE))
        else $error("slot mismatch did not end cycle");
    // address load clock on slave start
    alclk_a: assert property (@(posedge REF_CLK) disable iff (!NRST)
        (fall && s_st == bbc_pkg::S_IDLE && !BUS_START_N) |=> LOCAL_ADDR_LOAD_CLK)
        else $error("address load clock missed start");
endmodule // bbc_buffer_ctrl

// *** bbc_far_end.sv ***
/*
 bbc_far_end: backplane and local-board model facing the buffer block.
 Assumes REF_CLK runs from time zero; the bus clock is REF_CLK / 8.
*/
module bbc_far_end (
    // system clock
    input  wire logic REF_CLK,
    // backplane and local board lines
    output logic      BUS_CLK,
    output logic      BUS_START_N,
    output logic      BUS_ACK_N,
    output logic      BUS_TM0_N,
    output logic      SLOT_MATCH_N
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] div;       // four system clocks per bus phase
    logic       start_req; // start queued for next driving edge
    logic       start_hit; // queued start addresses this board
    logic       match_due; // slot answer due next cycle
    int         ack_wait;  // driving edges left until acknowledge
    int         tm0_wait;  // driving edges left until interim ack
    // all lines released at time zero
    initial begin
        {BUS_CLK, div, start_req, start_hit, match_due} = 6'h00;
        {BUS_START_N, BUS_ACK_N, BUS_TM0_N, SLOT_MATCH_N} = 4'hF;
        ack_wait = 0;
        tm0_wait = 0;
    end
    // free-running bus clock, edges kept away from system clock rise
    always @(negedge REF_CLK) begin
        div <= div + 2'h1;
        if (div == 2'h3) begin
            BUS_CLK <= ~BUS_CLK;
        end
    end
    // lines move only on driving edges; pull-ups make released lines high
    always @(posedge BUS_CLK) begin
        BUS_START_N  <= ~start_req;
        start_req    <= 1'h0;
        match_due    <= start_req & start_hit;
        SLOT_MATCH_N <= ~match_due;
        BUS_ACK_N    <= (ack_wait == 1) ? 1'h0 : 1'h1;
        BUS_TM0_N    <= (tm0_wait == 1) ? 1'h0 : 1'h1;
        ack_wait     <= (ack_wait > 0) ? ack_wait - 1 : 0;
        tm0_wait     <= (tm0_wait > 0) ? tm0_wait - 1 : 0;
    end
    // start cycle at next driving edge; hit says whether slot decode matches
    task request_start(input logic hit);
        start_req = 1'h1;
        start_hit = hit;
    endtask
    // acknowledge on the n-th driving edge from now, slow or prompt
    task request_ack(input int n);
        ack_wait = n;
    endtask
    // interim acknowledge on the n-th driving edge from now
    task request_tm0(input int n);
        tm0_wait = n;
    endtask
endmodule // bbc_far_end

// *** test_backplane_buffer_control.sv ***
/*
 test_backplane_buffer_control: scenario bench for bbc_buffer_ctrl.
 Assumes bbc_far_end supplies the bus clock and backplane lines.
*/
module test_backplane_buffer_control;
    timeunit 1ns;
    timeprecision 1ps;
    logic REF_CLK, NRST, BUS_CLK, BUS_START_N, BUS_ACK_N, BUS_TM0_N;
    logic MST_START, WRITE, BLOCK_XFER, SLOT_MATCH_N, SLAVE_GRANT_N;
    logic SLAVE_INTERIM_ACK_N, LOCAL_ACK_N, MASTER_HOLD_N, BUS_ACK_OUT_N;
    logic BUS_DRIVE_ENABLE_N, ADDR_SELECT_N, LOCAL_ADDR_LOAD_CLK;
    logic LOCAL_ADDR_ENABLE_N, LOCAL_DATA_LOAD_CLK, LOCAL_DATA_ENABLE_N;
    int   bad_count;  // mismatches seen
    int   num_checks; // comparisons made
    bbc_far_end bbc_far_end_inst (.REF_CLK(REF_CLK), .BUS_CLK(BUS_CLK),
        .BUS_START_N(BUS_START_N), .BUS_ACK_N(BUS_ACK_N),
        .BUS_TM0_N(BUS_TM0_N), .SLOT_MATCH_N(SLOT_MATCH_N));
    bbc_buffer_ctrl bbc_buffer_ctrl_inst (.REF_CLK(REF_CLK), .NRST(NRST),
        .BUS_CLK(BUS_CLK), .BUS_START_N(BUS_START_N), .BUS_ACK_N(BUS_ACK_N),
        .BUS_TM0_N(BUS_TM0_N), .BUS_ACK_OUT_N(BUS_ACK_OUT_N),
        .MST_START(MST_START), .WRITE(WRITE), .BLOCK_XFER(BLOCK_XFER),
        .SLOT_MATCH_N(SLOT_MATCH_N), .SLAVE_GRANT_N(SLAVE_GRANT_N),
        .SLAVE_INTERIM_ACK_N(SLAVE_INTERIM_ACK_N), .LOCAL_ACK_N(LOCAL_ACK_N),
        .MASTER_HOLD_N(MASTER_HOLD_N), .BUS_DRIVE_ENABLE_N(BUS_DRIVE_ENABLE_N),
        .ADDR_SELECT_N(ADDR_SELECT_N), .LOCAL_ADDR_LOAD_CLK(LOCAL_ADDR_LOAD_CLK),
        .LOCAL_ADDR_ENABLE_N(LOCAL_ADDR_ENABLE_N),
        .LOCAL_DATA_LOAD_CLK(LOCAL_DATA_LOAD_CLK),
        .LOCAL_DATA_ENABLE_N(LOCAL_DATA_ENABLE_N));
    // 50 MHz system clock
    always #10 REF_CLK = ~REF_CLK;
    // compare one output bit, four-state exact
    task check(input logic seen, input logic exp);
        num_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // settle point just after a sample edge (outputs landed, inputs safe)
    task at_fall;
        @(negedge BUS_CLK);
        repeat (2) @(negedge REF_CLK);
    endtask
    // settle point just after a driving edge
    task at_rise;
        @(posedge BUS_CLK);
        repeat (2) @(negedge REF_CLK);
    endtask
    // verdict and end of run, shared with the watchdog
    task results;
        if (bad_count == 0 && num_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // block read as master: interim ack then ack, data held by master hold
    task master_read;
        at_fall;
        {MST_START, WRITE, BLOCK_XFER, MASTER_HOLD_N} = 4'hA;
        at_rise;
        check(ADDR_SELECT_N, 1'h0);
        check(BUS_DRIVE_ENABLE_N, 1'h0);
        MST_START = 1'h0;
        bbc_far_end_inst.request_tm0(2);
        bbc_far_end_inst.request_ack(4);
        at_fall;
        check(LOCAL_ADDR_LOAD_CLK, 1'h1);
        at_rise;
        check(ADDR_SELECT_N, 1'h1);
        check(BUS_DRIVE_ENABLE_N, 1'h1);
        at_fall;
        check(LOCAL_DATA_LOAD_CLK, 1'h0);
        at_fall;
        check(LOCAL_DATA_LOAD_CLK, 1'h1);
        at_fall;
        check(LOCAL_DATA_LOAD_CLK, 1'h0);
        at_fall;
        check(LOCAL_DATA_LOAD_CLK, 1'h1);
        check(LOCAL_DATA_ENABLE_N, 1'h0);
        at_fall;
        check(LOCAL_DATA_ENABLE_N, 1'h0);
        MASTER_HOLD_N = 1'h1;
        at_fall;
        check(LOCAL_DATA_ENABLE_N, 1'h1);
    endtask
    // write as master: slow ack keeps the backplane driven
    task master_write;
        at_fall;
        {MST_START, WRITE, BLOCK_XFER} = 3'h6;
        at_rise;
        MST_START = 1'h0;
        bbc_far_end_inst.request_ack(3);
        repeat (4) begin
            check(BUS_DRIVE_ENABLE_N, 1'h0);
            at_rise;
        end
        check(BUS_DRIVE_ENABLE_N, 1'h1);
    endtask
    // single read as master, no hold: interim ack ignored, data enable one cycle
    task master_read_plain;
        at_fall;
        {MST_START, WRITE, BLOCK_XFER, MASTER_HOLD_N} = 4'h9;
        at_rise;
        check(BUS_DRIVE_ENABLE_N, 1'h0);
        MST_START = 1'h0;
        bbc_far_end_inst.request_tm0(2);
        bbc_far_end_inst.request_ack(3);
        repeat (3) at_fall;
        check(LOCAL_DATA_LOAD_CLK, 1'h0);
        at_fall;
        check(LOCAL_DATA_LOAD_CLK, 1'h1);
        check(LOCAL_DATA_ENABLE_N, 1'h0);
        at_fall;
        check(LOCAL_DATA_LOAD_CLK, 1'h0);
        check(LOCAL_DATA_ENABLE_N, 1'h1);
    endtask
    // slave cycle, grant after slot decode; blk stretches the first load
    // clock to two cycles; hit=0 must be dropped
    task slave_cycle(input logic wr, input logic blk, input logic hit);
        {WRITE, BLOCK_XFER, SLAVE_GRANT_N} = {wr, blk, 1'h1};
        at_fall;
        bbc_far_end_inst.request_start(hit);
        at_fall;
        check(LOCAL_ADDR_LOAD_CLK, 1'h1);
        at_fall;
        SLAVE_GRANT_N = 1'h0;
        at_fall;
        check(LOCAL_ADDR_ENABLE_N, ~hit);
        if (wr) check(LOCAL_DATA_LOAD_CLK, hit);
        if (wr) check(LOCAL_DATA_ENABLE_N, ~hit);
        LOCAL_ACK_N = 1'h0;
        at_fall;
        LOCAL_ACK_N = 1'h1;
        if (wr) check(LOCAL_DATA_LOAD_CLK, blk & hit);
        at_rise;
        check(BUS_ACK_OUT_N, ~hit);
        if (!wr) check(BUS_DRIVE_ENABLE_N, ~hit);
        at_rise;
        check(BUS_ACK_OUT_N, 1'h1);
        SLAVE_GRANT_N = 1'h1;
        at_fall;
        check(LOCAL_ADDR_ENABLE_N, 1'h1);
        check(LOCAL_DATA_ENABLE_N, 1'h1);
    endtask
    // block write as slave with grant already low at start
    task block_write;
        {WRITE, BLOCK_XFER, SLAVE_GRANT_N} = 3'h6;
        at_fall;
        bbc_far_end_inst.request_start(1'h1);
        at_fall;
        check(LOCAL_ADDR_ENABLE_N, 1'h0);
        check(LOCAL_DATA_LOAD_CLK, 1'h1);
        at_fall;
        check(LOCAL_DATA_LOAD_CLK, 1'h1);
        check(LOCAL_DATA_ENABLE_N, 1'h0);
        at_fall;
        check(LOCAL_DATA_LOAD_CLK, 1'h0);
        SLAVE_INTERIM_ACK_N = 1'h0;
        at_fall;
        SLAVE_INTERIM_ACK_N = 1'h1;
        check(LOCAL_DATA_LOAD_CLK, 1'h1);
        at_fall;
        check(LOCAL_DATA_LOAD_CLK, 1'h0);
        LOCAL_ACK_N = 1'h0;
        at_fall;
        LOCAL_ACK_N = 1'h1;
        check(LOCAL_DATA_LOAD_CLK, 1'h1);
        at_rise;
        check(BUS_ACK_OUT_N, 1'h0);
        at_rise;
        SLAVE_GRANT_N = 1'h1;
        at_fall;
        check(LOCAL_DATA_ENABLE_N, 1'h1);
    endtask
    // watchdog: whole run needs well under 2000 system clocks
    initial begin
        repeat (20000) @(posedge REF_CLK);
        bad_count++;
        results;
    end
    // main sequence: reset, idle levels, then each cycle kind
    initial begin
        {REF_CLK, NRST, MST_START, WRITE, BLOCK_XFER} = 5'h00;
        {SLAVE_GRANT_N, SLAVE_INTERIM_ACK_N, LOCAL_ACK_N, MASTER_HOLD_N} = 4'hF;
        bad_count = 0;
        num_checks = 0;
        repeat (10) @(negedge REF_CLK);
        NRST = 1'h1;
        repeat (4) @(negedge REF_CLK);
        check(&{BUS_DRIVE_ENABLE_N, ADDR_SELECT_N, LOCAL_ADDR_ENABLE_N,
            LOCAL_DATA_ENABLE_N, BUS_ACK_OUT_N, ~LOCAL_ADDR_LOAD_CLK,
            ~LOCAL_DATA_LOAD_CLK}, 1'h1);
        master_read;
        master_write;
        master_read_plain;
        slave_cycle(1'h0, 1'h0, 1'h1);
        slave_cycle(1'h1, 1'h0, 1'h1);
        slave_cycle(1'h1, 1'h1, 1'h1);
        slave_cycle(1'h0, 1'h0, 1'h0);
        block_write;
        results;
    end
endmodule // test_backplane_buffer_control
